// ==== design/pwm_top.sv ====
// Top of the four channel pwm controller: clock generator, registers, channels.
// Assumes a register master with one cycle strobes and read data one cycle later.
`default_nettype none
// Functional notes
// - Modulo counter gives eleven binary divisions
// - Two linear dividers make aux clocks
// - Divider fields reset to zero
// - Divided clocks stopped at reset
// - Thirteen clocks, per channel select
// - Sixteen bit channel counter
// - Left aligned wraps after period
// - Centre aligned counts up then down
// - Period is clock times period value, doubled when centre aligned
// - Duty value sets duty fraction
// - Polarity sets level at period start
// - Alignment bit selects mode, left default
// - Fixed low cases of duty/polarity
// - Fixed high cases once enabled
// - Polarity only changes while disabled
// - Period and duty double buffered
// - Resume exactly after clock stop
// - Config writes accepted with clock gated
// - One output line per channel
// - All access through mapped registers
// - Divide factor zero stops aux clock
// - Update value held until period end
// - Period end flag cleared by read
// - Enable bits start channels together
module pwm_top
	import pwm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_func_clk_en,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic [NUM_CH-1:0] o_waveform_output
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [MOD_W-1:0] mod_cnt;
		logic [DIV_W-1:0] aux_a_cnt;
		logic [DIV_W-1:0] aux_b_cnt;
		logic [DIV_W-1:0] aux_a_divide_factor;
		logic [PRE_W-1:0] aux_a_prescaler_select;
		logic [DIV_W-1:0] aux_b_divide_factor;
		logic [PRE_W-1:0] aux_b_prescaler_select;
		logic [NUM_CH-1:0] clk_sel_0;
		logic [NUM_CH-1:0] clk_sel_1;
		logic [NUM_CH-1:0] clk_sel_2;
		logic [NUM_CH-1:0] clk_sel_3;
		logic [NUM_CH-1:0] align;
		logic [NUM_CH-1:0] pol;
		logic [NUM_CH-1:0] upd_sel;
		logic [NUM_CH-1:0] imask;
		logic [NUM_CH-1:0] iflag;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic [NUM_CH-1:0] wave;
	} top_t;
	top_t q, d;
	// ----------------------------------------
	// Clock generator
	// ----------------------------------------
	logic [NUM_MOD_CLK-1:0] mod_tick;
	logic aux_a_tick, aux_b_tick;
	logic aux_a_src, aux_b_src;
	logic [PRE_W-1:0] ch_sel [NUM_CH];
	logic [NUM_CH-1:0] ch_tick;
	logic [NUM_CH-1:0] ch_wave, ch_pend, ch_en;
	logic [CNT_W-1:0] ch_cnt [NUM_CH];
	logic [CNT_W-1:0] ch_dty [NUM_CH];
	logic [CNT_W-1:0] ch_prd [NUM_CH];
	logic [NUM_CH-1:0] wr_dty, wr_prd, wr_upd, rd_hit;
	logic [NUM_CH-1:0] start, stop;
	logic [DATA_W-1:0] ch_rd [NUM_CH];
	logic ch_region;
	logic [1:0] ch_idx;
	logic [4:0] ch_ofs;
	assign ch_sel[0] = q.clk_sel_0;
	assign ch_sel[1] = q.clk_sel_1;
	assign ch_sel[2] = q.clk_sel_2;
	assign ch_sel[3] = q.clk_sel_3;
	// Only undivided tick runs in reset; no tick runs while gated
	always_comb begin
		mod_tick[0] = i_func_clk_en;
		for (int k = 1; k < NUM_MOD_CLK; k++) begin
			mod_tick[k] = i_func_clk_en
				&& ((q.mod_cnt & ((MOD_W'(1) << k) - MOD_W'(1))) == ((MOD_W'(1) << k) - MOD_W'(1)));
		end
	end
	assign aux_a_src = mod_tick[q.aux_a_prescaler_select];
	assign aux_b_src = mod_tick[q.aux_b_prescaler_select];
	assign aux_a_tick = aux_a_src && (q.aux_a_divide_factor != DIV_RST)
		&& (q.aux_a_cnt >= q.aux_a_divide_factor - DIV_ONE);
	assign aux_b_tick = aux_b_src && (q.aux_b_divide_factor != DIV_RST)
		&& (q.aux_b_cnt >= q.aux_b_divide_factor - DIV_ONE);
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (ch_sel[c] == SEL_AUX_A) begin
				ch_tick[c] = aux_a_tick;
			end else if (ch_sel[c] == SEL_AUX_B) begin
				ch_tick[c] = aux_b_tick;
			end else if (ch_sel[c] < SEL_AUX_A) begin
				ch_tick[c] = mod_tick[ch_sel[c]];
			end else begin
				ch_tick[c] = 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Mapped register access
	assign ch_region = (i_addr >= OFS_CH_BASE) && (i_addr < OFS_CH_BASE + NUM_CH * OFS_CH_STRIDE);
	assign ch_idx = i_addr[6:5];
	assign ch_ofs = i_addr[4:0];
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			rd_hit[c] = ch_region && (ch_idx == c[1:0]);
			wr_dty[c] = i_wr && rd_hit[c] && (ch_ofs == OFS_DUTY_VALUE);
			wr_prd[c] = i_wr && rd_hit[c] && (ch_ofs == OFS_PERIOD_VALUE);
			wr_upd[c] = i_wr && rd_hit[c] && (ch_ofs == OFS_CUPD);
		end
	end
	assign start = (i_wr && i_addr == OFS_ENA) ? i_wdata[NUM_CH-1:0] : '0;
	assign stop = (i_wr && i_addr == OFS_DIS) ? i_wdata[NUM_CH-1:0] : '0;
	// ----------------------------------------
	// Channels
	// ----------------------------------------
	// Four sixteen bit channels
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		pwm_channel u_ch (
			.i_sys_clk(i_sys_clk),
			.i_nrst(i_nrst),
			.i_tick(ch_tick[g]),
			.i_start(start[g]),
			.i_stop(stop[g]),
			.i_align(q.align[g]),
			.i_pol(q.pol[g]),
			.i_upd_sel(q.upd_sel[g]),
			.i_wr_dty(wr_dty[g]),
			.i_wr_prd(wr_prd[g]),
			.i_wr_upd(wr_upd[g]),
			.i_wdata(i_wdata[CNT_W-1:0]),
			.o_wave(ch_wave[g]),
			.o_period_end(ch_pend[g]),
			.o_enabled(ch_en[g]),
			.o_cnt(ch_cnt[g]),
			.o_dty(ch_dty[g]),
			.o_prd(ch_prd[g])
		);
		assign ch_rd[g] = {16'h0000, 5'h00, q.upd_sel[g], q.pol[g], q.align[g], 4'h0, ch_sel[g]};
	end
	// ----------------------------------------
	// Register file and read path
	// ----------------------------------------
	always_comb begin
		d = q;
		d.wave = ch_wave;
		d.mod_cnt = i_func_clk_en ? q.mod_cnt + 1'b1 : q.mod_cnt;
		if (aux_a_src) begin
			d.aux_a_cnt = aux_a_tick ? DIV_RST : q.aux_a_cnt + DIV_ONE;
		end
		if (aux_b_src) begin
			d.aux_b_cnt = aux_b_tick ? DIV_RST : q.aux_b_cnt + DIV_ONE;
		end
		// Config writes do not need the functional clock
		if (i_wr && i_addr == OFS_MODE) begin
			d.aux_a_divide_factor = i_wdata[AUX_A_DIVIDE_FACTOR_LSB +: DIV_W];
			d.aux_a_prescaler_select = i_wdata[AUX_A_PRESCALER_SELECT_LSB +: PRE_W];
			d.aux_b_divide_factor = i_wdata[AUX_B_DIVIDE_FACTOR_LSB +: DIV_W];
			d.aux_b_prescaler_select = i_wdata[AUX_B_PRESCALER_SELECT_LSB +: PRE_W];
			d.aux_a_cnt = DIV_RST;
			d.aux_b_cnt = DIV_RST;
		end
		if (i_wr && i_addr == OFS_IER) begin
			d.imask = q.imask | i_wdata[NUM_CH-1:0];
		end
		if (i_wr && i_addr == OFS_IDR) begin
			d.imask = q.imask & ~i_wdata[NUM_CH-1:0];
		end
		for (int c = 0; c < NUM_CH; c++) begin
			// Mode bits except update select writable only while disabled
			if (i_wr && rd_hit[c] && ch_ofs == OFS_CMR) begin
				d.upd_sel[c] = i_wdata[CMR_UPD_BIT];
				if (!ch_en[c]) begin
					d.align[c] = i_wdata[CMR_ALG_BIT];
					d.pol[c] = i_wdata[CMR_POL_BIT];
					case (c)
						0: d.clk_sel_0 = i_wdata[CMR_PRE_LSB +: PRE_W];
						1: d.clk_sel_1 = i_wdata[CMR_PRE_LSB +: PRE_W];
						2: d.clk_sel_2 = i_wdata[CMR_PRE_LSB +: PRE_W];
						default: d.clk_sel_3 = i_wdata[CMR_PRE_LSB +: PRE_W];
					endcase
				end
			end
		end
		d.rdata = DATA_ZERO;
		if (i_rd) begin
			case (i_addr)
				OFS_MODE: d.rdata = {4'h0, q.aux_b_prescaler_select, q.aux_b_divide_factor,
					4'h0, q.aux_a_prescaler_select, q.aux_a_divide_factor};
				OFS_STAT: d.rdata = {28'h0000000, ch_en};
				OFS_IMR: d.rdata = {28'h0000000, q.imask};
				OFS_ISR: d.rdata = {28'h0000000, q.iflag};
				default: begin
					if (ch_region) begin
						case (ch_ofs)
							OFS_CMR: d.rdata = ch_rd[ch_idx];
							OFS_DUTY_VALUE: d.rdata = {16'h0000, ch_dty[ch_idx]};
							OFS_PERIOD_VALUE: d.rdata = {16'h0000, ch_prd[ch_idx]};
							OFS_CCNT: d.rdata = {16'h0000, ch_cnt[ch_idx]};
							default: d.rdata = DATA_ZERO;
						endcase
					end
				end
			endcase
		end
		if (i_rd && i_addr == OFS_ISR) begin
			d.iflag = ch_pend;
		end else begin
			d.iflag = q.iflag | ch_pend;
		end
		d.irq = |(d.iflag & q.imask);
	end
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_rdata = q.rdata;
	assign o_irq = q.irq;
	assign o_waveform_output = q.wave;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_AUX_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.aux_a_divide_factor == DIV_RST) |-> !aux_a_tick)
		else $error("aux clock a runs with zero factor");
	AST_GATED: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		!i_func_clk_en |-> (ch_tick == '0))
		else $error("channel tick while clock gated");
	AST_ISR_CLR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(i_rd && i_addr == OFS_ISR && ch_pend == '0) |=> q.iflag == '0)
		else $error("status read did not clear flags");
	AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(ch_pend != '0) |=> ((q.iflag & $past(ch_pend)) == $past(ch_pend)))
		else $error("period end flag lost");
	AST_SYNC: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(start != '0) |=> ((ch_en & $past(start)) == $past(start)))
		else $error("channels not started together");
	AST_POL_LOCK: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(ch_en[0] && $past(ch_en[0])) |-> $stable(q.pol[0]))
		else $error("polarity changed while enabled");
	COV_IRQ: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) q.irq ##1 !q.irq);
	COV_AUX: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) aux_b_tick);
endmodule
`default_nettype wire

// ==== design/pwm_pkg.sv ====
// Package for the four channel pwm controller: offsets, fields, resets, states.
// Assumes a single 40 MHz clock domain and a plain register port.
package pwm_pkg;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PRE_W = 4;
	localparam int DIV_W = 8;
	localparam int MOD_W = 10;
	localparam int NUM_MOD_CLK = 11;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_ENA = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_DIS = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STAT = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_IER = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_IDR = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_IMR = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_ISR = 12'h01C;
	localparam logic [ADDR_W-1:0] OFS_CH_BASE = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_CH_STRIDE = 12'h020;
	localparam logic [4:0] OFS_CMR = 5'h00;
	localparam logic [4:0] OFS_DUTY_VALUE = 5'h04;
	localparam logic [4:0] OFS_PERIOD_VALUE = 5'h08;
	localparam logic [4:0] OFS_CCNT = 5'h0C;
	localparam logic [4:0] OFS_CUPD = 5'h10;
	// Mode register fields
	localparam int AUX_A_DIVIDE_FACTOR_LSB = 0;
	localparam int AUX_A_PRESCALER_SELECT_LSB = 8;
	localparam int AUX_B_DIVIDE_FACTOR_LSB = 16;
	localparam int AUX_B_PRESCALER_SELECT_LSB = 24;
	// Channel mode register fields
	localparam int CMR_PRE_LSB = 0;
	localparam int CMR_ALG_BIT = 8;
	localparam int CMR_POL_BIT = 9;
	localparam int CMR_UPD_BIT = 10;
	// Clock select codes, reset values and constants
	localparam logic [PRE_W-1:0] SEL_AUX_A = 4'hB;
	localparam logic [PRE_W-1:0] SEL_AUX_B = 4'hC;
	localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
	localparam logic [PRE_W-1:0] PRE_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_UP = 2'b01,
		CH_DOWN = 2'b11
	} ch_state_t;
endpackage

// ==== design/pwm_channel.sv ====
// One pwm channel: counter, comparator, double buffered period and duty.
// Assumes a one cycle tick from the clock selector and enable from the top.
`default_nettype none
module pwm_channel
	import pwm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_nrst,
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic i_stop,
	input wire logic i_align,
	input wire logic i_pol,
	input wire logic i_upd_sel,
	input wire logic i_wr_dty,
	input wire logic i_wr_prd,
	input wire logic i_wr_upd,
	input wire logic [CNT_W-1:0] i_wdata,
	output logic o_wave,
	output logic o_period_end,
	output logic o_enabled,
	output logic [CNT_W-1:0] o_cnt,
	output logic [CNT_W-1:0] o_dty,
	output logic [CNT_W-1:0] o_prd
);
	typedef struct packed {
		ch_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] dty;
		logic [CNT_W-1:0] prd;
		logic [CNT_W-1:0] upd;
		logic upd_pend;
		logic upd_tgt;
		logic wave;
		logic pend;
	} ch_t;
	ch_t q, d;
	logic last;
	logic at_top;
	always_comb begin
		d = q;
		d.pend = 1'b0;
		at_top = (q.cnt >= q.prd);
		last = 1'b0;
		if (!q.upd_pend) begin
			d.upd_tgt = i_upd_sel;
		end
		if (i_wr_upd) begin
			d.upd = i_wdata;
			d.upd_pend = 1'b1;
			d.upd_tgt = i_upd_sel;
		end
		if (q.st == CH_IDLE) begin
			if (i_wr_dty) begin
				d.dty = i_wdata;
			end
			if (i_wr_prd) begin
				d.prd = i_wdata;
			end
			d.wave = i_pol;
		end
		case (q.st)
			CH_IDLE: begin
				if (i_start) begin
					d.st = CH_UP;
					d.cnt = CNT_ZERO;
					d.wave = (q.dty == CNT_ZERO) ? ~i_pol : i_pol;
				end
			end
			CH_UP: begin
				if (i_tick) begin
					if (!i_align && (q.cnt + CNT_ONE >= q.prd)) begin
						last = 1'b1;
					end else if (at_top) begin
						d.st = CH_DOWN;
						d.cnt = q.cnt - CNT_ONE;
					end else begin
						d.cnt = q.cnt + CNT_ONE;
					end
				end
			end
			CH_DOWN: begin
				if (i_tick) begin
					if (q.cnt <= CNT_ONE) begin
						last = 1'b1;
					end else begin
						d.cnt = q.cnt - CNT_ONE;
					end
				end
			end
			default: begin
				d.st = CH_IDLE;
			end
		endcase
		// Up match leaves, down match returns
		if (q.st != CH_IDLE && i_tick && !last && d.cnt == q.dty && q.dty != CNT_ZERO
			&& q.dty != q.prd) begin
			d.wave = (d.st == CH_DOWN) ? i_pol : ~i_pol;
		end
		if (last) begin
			d.st = CH_UP;
			d.cnt = CNT_ZERO;
			d.pend = 1'b1;
			if (q.upd_pend) begin
				d.upd_pend = 1'b0;
				if (q.upd_tgt) begin
					d.prd = q.upd;
				end else begin
					d.dty = q.upd;
				end
			end
			d.wave = (d.dty == CNT_ZERO) ? ~i_pol : i_pol;
			if (d.dty == d.prd && d.dty != CNT_ZERO) begin
				d.wave = i_pol;
			end
		end
		if (i_stop && q.st != CH_IDLE) begin
			d.st = CH_IDLE;
			d.cnt = CNT_ZERO;
			d.wave = i_pol;
		end
	end
	// State held while no tick arrives
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign o_wave = q.wave;
	assign o_period_end = q.pend;
	assign o_enabled = (q.st != CH_IDLE);
	assign o_cnt = q.cnt;
	assign o_dty = q.dty;
	assign o_prd = q.prd;
	AST_ZERO_DUTY: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.st == CH_UP && $past(q.st) == CH_IDLE && q.dty == CNT_ZERO) |-> q.wave == ~i_pol)
		else $error("zero duty level wrong");
	AST_IDLE_POL: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.st == CH_IDLE && $past(q.st) == CH_IDLE && !$past(i_start))
		|-> q.wave == $past(i_pol))
		else $error("idle level not polarity");
	AST_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.pend |-> q.cnt == CNT_ZERO)
		else $error("period end without counter clear");
	AST_COUNT_BOUND: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.st == CH_DOWN) |-> q.cnt < q.prd)
		else $error("down count above period");
	AST_UPD_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
		(q.upd_pend && !last && q.st != CH_IDLE) |=> $stable(q.prd))
		else $error("period changed mid cycle");
	COV_CENTRE: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.st == CH_DOWN ##1 q.pend);
	COV_UPDATE: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
		q.upd_pend && last);
endmodule
`default_nettype wire

// ==== verification/pwm_load_model.sv ====
// Load on one waveform line: counts rising edges, keeps period and high time.
// Assumes the line is sampled on the rising system clock edge.
`default_nettype none
module pwm_load_model (
	input wire logic i_sys_clk,
	input wire logic i_wave,
	output logic [31:0] o_rises,
	output logic [31:0] o_period,
	output logic [31:0] o_high
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] cyc;
	logic [31:0] last;
	logic prev;
	initial begin
		cyc = 32'h0;
		last = 32'h0;
		prev = 1'b0;
		o_rises = 32'h0;
		o_period = 32'h0;
		o_high = 32'h0;
	end
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 32'h1;
		prev <= i_wave;
		if (i_wave && !prev) begin
			o_rises <= o_rises + 32'h1;
			o_period <= cyc - last;
			last <= cyc;
		end
		if (!i_wave && prev) begin
			o_high <= cyc - last;
		end
	end
endmodule
`default_nettype wire

// ==== verification/test_four_channel_pwm_controller.sv ====
// Self-checking bench for the pwm controller top: registers, waveforms, gating.
// Assumes one 40 MHz clock and a register port with reads answered next cycle.
`default_nettype none
module test_four_channel_pwm_controller
	import pwm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [ADDR_W-1:0] addr = 12'h000;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic [NUM_CH-1:0] wave;
	logic [31:0] rises [NUM_CH];
	logic [31:0] per [NUM_CH];
	logic [31:0] hi [NUM_CH];
	logic [DATA_W-1:0] r;
	logic [DATA_W-1:0] r2;
	int error_cnt = 0;
	int checks_done = 0;
	int p;
	int d;
	int s;
	int n;
	always #12.5 clk = ~clk;
	pwm_top DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_func_clk_en(clk_en), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
		.o_waveform_output(wave));
	for (genvar c = 0; c < NUM_CH; c++) begin : g_load
		pwm_load_model u_load (.i_sys_clk(clk), .i_wave(wave[c]), .o_rises(rises[c]),
			.o_period(per[c]), .o_high(hi[c]));
	end
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task automatic print_verdict();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_wave(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t wave got %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	function automatic logic [ADDR_W-1:0] ch_a(input int c, input logic [4:0] o);
		return OFS_CH_BASE + OFS_CH_STRIDE * ADDR_W'(c) + ADDR_W'(o);
	endfunction
	function automatic logic [DATA_W-1:0] cmr(input int sel, alg, pol, upd);
		return DATA_W'((upd << CMR_UPD_BIT) | (pol << CMR_POL_BIT) | (alg << CMR_ALG_BIT) | sel);
	endfunction
	function automatic int exp_per(input int prd, div, alg);
		return alg ? 2 * prd * div : prd * div;
	endfunction
	function automatic int exp_hi(input int prd, dty, div, pol, alg);
		return (alg ? 2 : 1) * (pol ? dty : prd - dty) * div;
	endfunction
	task automatic setup(input int c, input logic [DATA_W-1:0] m, input int prd, dty);
		wr_reg(ch_a(c, OFS_CMR), m);
		wr_reg(ch_a(c, OFS_PERIOD_VALUE), DATA_W'(prd));
		wr_reg(ch_a(c, OFS_DUTY_VALUE), DATA_W'(dty));
	endtask
	task automatic cfg(input int c, input logic [DATA_W-1:0] m, input int prd, dty);
		wr_reg(OFS_DIS, DATA_W'(1) << c);
		setup(c, m, prd, dty);
		wr_reg(OFS_ENA, DATA_W'(1) << c);
	endtask
	// Three full rises so the last period and high time are clean
	task automatic measure(input int c);
		logic [31:0] r0;
		int k;
		r0 = rises[c];
		k = 0;
		while (rises[c] < r0 + 32'h3 && k < 20000) begin
			@(posedge clk);
			k++;
		end
	endtask
	task automatic steady(input int c);
		logic [31:0] r0;
		// Let an edge already in the output pipeline land first
		repeat (4) @(posedge clk);
		r0 = rises[c];
		repeat (60) @(posedge clk);
		#1;
		cmp_wave(rises[c], r0);
	endtask
	task automatic run_wave(input int c, sel, alg, pol, prd, dty, div);
		cfg(c, cmr(sel, alg, pol, 0), prd, dty);
		measure(c);
		cmp_wave(per[c], 32'(exp_per(prd, div, alg)));
		cmp_wave(hi[c], 32'(exp_hi(prd, dty, div, pol, alg)));
	endtask
	// ----------------------------------------
	// Watchdog, longest legal run is far shorter
	// ----------------------------------------
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(80));
		repeat (20) @(posedge clk);
		cmp_wave(32'(wave), 32'h0);
		nrst <= 1'b1;
		rd_reg(OFS_MODE, r);
		cmp_reg(r, DATA_ZERO);
		rd_reg(OFS_STAT, r);
		cmp_reg(r, DATA_ZERO);
		rd_reg(OFS_IMR, r);
		cmp_reg(r, DATA_ZERO);
		rd_reg(12'h100, r);
		cmp_reg(r, DATA_ZERO);
		for (int c = 0; c < NUM_CH; c++) begin
			for (int o = 0; o < 16; o += 4) begin
				rd_reg(ch_a(c, 5'(o)), r);
				cmp_reg(r, DATA_ZERO);
			end
		end
		// Corners then random shapes over channels and clocks
		run_wave(0, 0, 0, 0, 2, 1, 1);
		run_wave(1, 3, 0, 1, 5, 4, 8);
		run_wave(2, 10, 0, 0, 2, 1, 1024);
		for (int i = 0; i < 8; i++) begin
			p = 4 + $urandom_range(15);
			d = 1 + $urandom_range(p - 2);
			s = $urandom_range(2);
			run_wave(i % NUM_CH, s, i % 2, $urandom_range(1), p, d, 1 << s);
		end
		wr_reg(OFS_MODE, 32'h0202_0103);
		rd_reg(OFS_MODE, r);
		cmp_reg(r, 32'h0202_0103);
		run_wave(0, 11, 0, 0, 5, 2, 6);
		run_wave(1, 12, 0, 1, 5, 2, 8);
		wr_reg(OFS_MODE, 32'h0202_0100);
		steady(0);
		wr_reg(OFS_DIS, 32'hF);
		for (int k = 0; k < 4; k++) begin
			cfg(3, cmr(0, 0, k / 2, 0), 8, (k % 2) ? 8 : 0);
			repeat (5) @(posedge clk);
			steady(3);
			cmp_wave(32'(wave[3]), 32'((k / 2) ^ ((k % 2) ? 0 : 1)));
		end
		wr_reg(OFS_DIS, 32'h8);
		for (int k = 1; k >= 0; k--) begin
			wr_reg(ch_a(3, OFS_CMR), cmr(0, 0, k, 0));
			repeat (3) @(posedge clk);
			#1;
			cmp_wave(32'(wave[3]), 32'(k));
		end
		// Buffered updates while running; direct writes are refused
		cfg(0, cmr(0, 0, 0, 0), 10, 5);
		measure(0);
		wr_reg(ch_a(0, OFS_CMR), cmr(0, 0, 1, 0));
		wr_reg(ch_a(0, OFS_CUPD), 32'h3);
		wr_reg(ch_a(0, OFS_DUTY_VALUE), 32'h7);
		measure(0);
		rd_reg(ch_a(0, OFS_DUTY_VALUE), r);
		cmp_reg(r, 32'h3);
		cmp_wave(hi[0], 32'h7);
		rd_reg(ch_a(0, OFS_CMR), r);
		cmp_reg(r, cmr(0, 0, 0, 0));
		wr_reg(ch_a(0, OFS_CMR), cmr(0, 0, 0, 1));
		wr_reg(ch_a(0, OFS_CUPD), 32'hE);
		measure(0);
		cmp_wave(per[0], 32'hE);
		rd_reg(ch_a(0, OFS_PERIOD_VALUE), r);
		cmp_reg(r, 32'hE);
		// Period end flag: raise, clear by read, mask
		wr_reg(OFS_IER, 32'h1);
		// Stale flags would raise the line off the period grid
		rd_reg(OFS_ISR, r);
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp_wave(32'(irq), 32'h1);
		rd_reg(OFS_IMR, r);
		cmp_reg(r, 32'h1);
		rd_reg(OFS_ISR, r);
		cmp_reg(r & 32'h1, 32'h1);
		@(posedge clk);
		#1;
		cmp_wave(32'(irq), 32'h0);
		wr_reg(OFS_IDR, 32'h1);
		rd_reg(OFS_IMR, r);
		cmp_reg(r, DATA_ZERO);
		repeat (40) @(posedge clk);
		#1;
		cmp_wave(32'(irq), 32'h0);
		// Gated clock freezes state, registers still writable
		@(posedge clk);
		clk_en <= 1'b0;
		rd_reg(ch_a(0, OFS_CCNT), r);
		repeat (20) @(posedge clk);
		rd_reg(ch_a(0, OFS_CCNT), r2);
		cmp_reg(r2, r);
		wr_reg(ch_a(2, OFS_CMR), cmr(5, 0, 1, 0));
		rd_reg(ch_a(2, OFS_CMR), r);
		cmp_reg(r, cmr(5, 0, 1, 0));
		@(posedge clk);
		clk_en <= 1'b1;
		repeat (3) @(posedge clk);
		rd_reg(ch_a(0, OFS_CCNT), r);
		cmp_reg(32'(r !== r2), 32'h1);
		// One write starts two channels in lockstep
		wr_reg(OFS_DIS, 32'hF);
		setup(1, cmr(1, 0, 0, 0), 9, 4);
		setup(2, cmr(1, 0, 0, 0), 9, 4);
		wr_reg(OFS_ENA, 32'h6);
		rd_reg(OFS_STAT, r);
		cmp_reg(r, 32'h6);
		n = 0;
		repeat (60) begin
			@(posedge clk);
			#1;
			n += (wave[1] !== wave[2]);
		end
		cmp_wave(32'(n), 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
